// ==== verif/enable_checker.sv ====
`timescale 1ns/1ps
module enable_checker #(
  parameter WIDTH = 4
) (
  input wire aclk, // clock
  input wire aresetn, // synchronous reset, active low
  input wire s_axi_awvalid, // write address valid
  input wire s_axi_awready, // write address ready
  input wire s_axi_wvalid, // write data valid
  input wire s_axi_wready, // write data ready
  input wire s_axi_arvalid, // read address valid
  input wire s_axi_arready, // read address ready
  input wire s_axi_rvalid, // read valid
  input wire global_enable_bit_q, // global enable
  input wire [11:0] s_axi_awaddr, // write address
  input wire [11:0] s_axi_araddr, // read address
  input wire [31:0] s_axi_wdata, // write data
  input wire [31:0] s_axi_rdata, // read data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire [WIDTH-1:0] trig_in, // raw trigger-to-channel
  input wire [WIDTH-1:0] chan_in, // raw channel-to-trigger
  input wire [WIDTH-1:0] trig_out_q, // gated trigger-to-channel
  input wire [WIDTH-1:0] chan_out_q // gated channel-to-trigger
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ctrl_write;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr[11:2] == 0;
  endsequence
  sequence ctrl_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 0;
  endsequence
  write_sets_a:
    assert property (ctrl_write ##0 s_axi_wstrb[0] |-> ##2
      global_enable_bit_q == $past(s_axi_wdata[0], 2)) else $error("enable not written");
  masked_keeps_a:
    assert property (ctrl_write ##0 !s_axi_wstrb[0] |-> ##2
      global_enable_bit_q == $past(global_enable_bit_q, 2)) else $error("masked write");
  read_back_a:
    assert property (ctrl_read |=> s_axi_rvalid &&
      s_axi_rdata == {31'h0, $past(global_enable_bit_q)}) else $error("bad readback");
  gate_off_a:
    assert property (!global_enable_bit_q |=> trig_out_q == 0 && chan_out_q == 0)
      else $error("gated output leaked");
  gate_on_a:
    assert property (global_enable_bit_q |=> trig_out_q == $past(trig_in) &&
      chan_out_q == $past(chan_in)) else $error("gated output wrong");
  reset_clear_a:
    assert property (disable iff (1'b0) !aresetn |=> !global_enable_bit_q)
      else $error("enable not cleared");
endmodule // enable_checker

bind cross_trigger_global_enable enable_checker #(.WIDTH(WIDTH)) u_chk (.*);

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0;
  reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 0, trig_in = 0, chan_in = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire global_enable_bit_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] trig_out_q, chan_out_q;
  integer n_errors = 0, num_checks = 0;
  // identity value is arbitrary
  cross_trigger_global_enable #(.COMP_IDENT_0(8'h3c)) u_cross_trigger_global_enable (.*);
  always #20 aclk = ~aclk;
  task chk(input [31:0] g, input [31:0] e); begin
    num_checks = num_checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  end endtask
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] r); begin
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, r);
  end endtask
  task rd(input [11:0] a, input [31:0] e, input [1:0] r); begin
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  end endtask
  task gate(input [3:0] v, input on); begin
    @(posedge aclk);
    trig_in <= v; chan_in <= v ^ 4'hf;
    repeat (2) @(posedge aclk);
    #1;
    chk(trig_out_q, on ? trig_in : 0);
    chk(chan_out_q, on ? chan_in : 0);
    chk(global_enable_bit_q, on);
  end endtask
  task complete_run; begin
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end endtask
  // ==========================================
  // tests
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(12'h000, 0, 0);
    gate(4'h9, 0);
    wr(12'h000, 32'hffffffff, 4'hf, 0);
    rd(12'h000, 1, 0);
    wr(12'h000, 0, 4'he, 0);
    rd(12'h000, 1, 0);
    gate(4'ha, 1);
    wr(12'h000, 32'hfffffffe, 4'hf, 0);
    rd(12'h000, 0, 0);
    gate(4'h5, 0);
    rd(12'hff0, 32'h3c, 0);
    wr(12'h004, 1, 4'hf, 2'h2);
    rd(12'h004, 0, 2'h2);
    wr(12'h000, 1, 4'h1, 0);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(12'h000, 0, 0);
    complete_run;
  end
  initial begin
    #200000;
    n_errors = n_errors + 1;
    complete_run;
  end
endmodule // tb

// ==== verilog/cross_trigger_global_enable.v ====
// Function
// - control register is readable and writable
// - bit 0 written sets global enable
// - global enable resets to zero
// - disabled means no trigger mapping propagates
`timescale 1ns/1ps
`include "cross_trigger_map.vh"

module cross_trigger_global_enable #(
  parameter WIDTH = 4,
  parameter [7:0] PERIPH_IDENT_7 = 8'h01, // arbitrary value
  parameter [7:0] PERIPH_IDENT_0 = 8'h02, // arbitrary value
  parameter [7:0] PERIPH_IDENT_1 = 8'h03, // arbitrary value
  parameter [7:0] PERIPH_IDENT_2 = 8'h04, // arbitrary value
  parameter [7:0] PERIPH_IDENT_3 = 8'h06, // arbitrary value
  parameter [7:0] COMP_IDENT_0 = 8'h07, // arbitrary value
  parameter [7:0] COMP_IDENT_1 = 8'h08, // arbitrary value
  parameter [7:0] COMP_IDENT_2 = 8'h09, // arbitrary value
  parameter [7:0] COMP_IDENT_3 = 8'h0a // arbitrary value
) (
  input wire aclk, // clock
  input wire aresetn, // synchronous reset, active low
  input wire [11:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [11:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read valid
  input wire s_axi_rready, // read ready
  input wire [WIDTH-1:0] trig_in, // raw trigger-to-channel events
  input wire [WIDTH-1:0] chan_in, // raw channel-to-trigger events
  output wire [WIDTH-1:0] trig_out_q, // gated trigger-to-channel
  output wire [WIDTH-1:0] chan_out_q, // gated channel-to-trigger
  output reg global_enable_bit_q // global enable
);

  reg aw_held_q;
  reg w_held_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg wlane0_q;
  reg global_enable_bit_d;
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;
  wire wr_go;
  wire ar_go;
  wire ctrl_hit;
  wire [11:0] ar_word;

  // ==========================================================
  // address decode
  function mapped;
    input [11:0] a;
    begin
      case (a)
        `OFS_GLOBAL_CONTROL, `OFS_PERIPH_IDENT_7, `OFS_PERIPH_IDENT_0,
        `OFS_PERIPH_IDENT_1, `OFS_PERIPH_IDENT_2, `OFS_PERIPH_IDENT_3,
        `OFS_COMP_IDENT_0, `OFS_COMP_IDENT_1, `OFS_COMP_IDENT_2,
        `OFS_COMP_IDENT_3: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  function [31:0] read_word;
    input [11:0] a;
    input en;
    begin
      case (a)
        `OFS_GLOBAL_CONTROL: read_word = {31'h0, en};
        `OFS_PERIPH_IDENT_7: read_word = {24'h0, PERIPH_IDENT_7};
        `OFS_PERIPH_IDENT_0: read_word = {24'h0, PERIPH_IDENT_0};
        `OFS_PERIPH_IDENT_1: read_word = {24'h0, PERIPH_IDENT_1};
        `OFS_PERIPH_IDENT_2: read_word = {24'h0, PERIPH_IDENT_2};
        `OFS_PERIPH_IDENT_3: read_word = {24'h0, PERIPH_IDENT_3};
        `OFS_COMP_IDENT_0: read_word = {24'h0, COMP_IDENT_0};
        `OFS_COMP_IDENT_1: read_word = {24'h0, COMP_IDENT_1};
        `OFS_COMP_IDENT_2: read_word = {24'h0, COMP_IDENT_2};
        `OFS_COMP_IDENT_3: read_word = {24'h0, COMP_IDENT_3};
        default: read_word = 32'h0;
      endcase
    end
  endfunction

  // ==========================================================
  // address alignment and response
  function [11:0] word_addr;
    input [11:0] a;
    begin
      word_addr = {a[11:2], 2'b00};
    end
  endfunction

  function [1:0] resp_for;
    input [11:0] a;
    begin
      resp_for = mapped(a) ? `RESP_OKAY : `RESP_SLVERR;
    end
  endfunction

  // ==========================================================
  // write channel
  // respond only once both halves are held
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0;
      wlane0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= word_addr(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wlane0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= resp_for(awaddr_q);
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // control register
  // only lane 0 carries the enable bit; other lanes are dropped
  assign ctrl_hit = (awaddr_q == `OFS_GLOBAL_CONTROL) && wlane0_q;

  always @* begin
    global_enable_bit_d = global_enable_bit_q;
    if (wr_go && ctrl_hit) begin
      global_enable_bit_d = wdata_q[`GLOBAL_ENABLE_POS];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      global_enable_bit_q <= `GLOBAL_ENABLE_RST;
    end else begin
      global_enable_bit_q <= global_enable_bit_d;
    end
  end

  // ==========================================================
  // read channel
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign ar_word = word_addr(s_axi_araddr);

  // read data only moves when an address is accepted
  always @* begin
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (ar_go) begin
      rdata_d = read_word(ar_word, global_enable_bit_q);
      rresp_d = resp_for(ar_word);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      if (ar_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // mapping gate
  trigger_gate #(
    .WIDTH(WIDTH)
  ) u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(global_enable_bit_q),
    .trig_in(trig_in),
    .chan_in(chan_in),
    .trig_out_q(trig_out_q),
    .chan_out_q(chan_out_q)
  );

endmodule // cross_trigger_global_enable

// ==== verilog/cross_trigger_map.vh ====
`ifndef CROSS_TRIGGER_MAP_VH
`define CROSS_TRIGGER_MAP_VH

// ==========================================================
// register byte offsets
`define OFS_GLOBAL_CONTROL 12'h000
`define OFS_PERIPH_IDENT_7 12'hfdc
`define OFS_PERIPH_IDENT_0 12'hfe0
`define OFS_PERIPH_IDENT_1 12'hfe4
`define OFS_PERIPH_IDENT_2 12'hfe8
`define OFS_PERIPH_IDENT_3 12'hfec
`define OFS_COMP_IDENT_0 12'hff0
`define OFS_COMP_IDENT_1 12'hff4
`define OFS_COMP_IDENT_2 12'hff8
`define OFS_COMP_IDENT_3 12'hffc

// ==========================================================
// fields and reset values
`define GLOBAL_ENABLE_POS 0
`define GLOBAL_ENABLE_RST 1'b0

// ==========================================================
// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== verilog/trigger_gate.v ====
`timescale 1ns/1ps
// ==========================================================
// gates trigger and channel paths with the global enable
module trigger_gate #(
  parameter WIDTH = 4
) (
  input wire aclk, // clock
  input wire aresetn, // synchronous reset, active low
  input wire enable, // global enable
  input wire [WIDTH-1:0] trig_in, // raw trigger-to-channel events
  input wire [WIDTH-1:0] chan_in, // raw channel-to-trigger events
  output reg [WIDTH-1:0] trig_out_q, // gated trigger-to-channel
  output reg [WIDTH-1:0] chan_out_q // gated channel-to-trigger
);

  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_out_q <= {WIDTH{1'b0}};
      chan_out_q <= {WIDTH{1'b0}};
    end else begin
      trig_out_q <= enable ? trig_in : {WIDTH{1'b0}};
      chan_out_q <= enable ? chan_in : {WIDTH{1'b0}};
    end
  end

endmodule // trigger_gate
